// ### gaem_top.sv
// Global alarm enable masks, master gate and register port
//
// Notes on behaviour
// - State mask: one enable per module state, bits 8 down to 0.
// - State mask resets to 006Ah: fault, ready, tx-off, low-power enabled.
// - General status mask bits AND with matching latch bits toward the alarm.
// - Bit 15 is master enable; cleared keeps the global alarm low.
// - General status mask resets to A7F8h; bits 14-8 reserved, unused.
// - All enabled latch results OR together, gated by master, drive alarm.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module gaem_top (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [15:0] addr,
  input wire logic [15:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [15:0] rd_data,
  input wire logic [8:0] state_change_latch,
  input wire logic [15:0] general_status_latch,
  input wire logic other_enabled_alarm,
  input wire logic [15:0] vendor_latch_in,
  output logic global_alarm_out,
  output logic irq
);

  // ************************************************************
  // Register storage
  // ************************************************************
  logic [15:0] state_mask_q;
  logic [15:0] gs_mask_q;
  logic [15:0] vendor_latch_q;
  logic [2:0] irq_enable_q;
  logic [2:0] irq_status_q;
  logic [15:0] rd_data_q;
  logic alarm_q;

  logic hit_state;
  logic hit_gs;
  logic hit_irq_clear;
  logic hit_irq_enable;
  logic wr_state;
  logic wr_gs;

  logic [8:0] state_hits;
  logic [7:0] gs_hits;
  logic any_source;
  logic master_en;
  logic alarm_d;
  logic [2:0] irq_set;
  logic [2:0] irq_clr;
  logic [15:0] rd_mux;

  // ************************************************************
  // Address decode
  // ************************************************************
  always_comb begin
    hit_state = (addr == gaem_pkg::OFS_STATE_MASK);
    hit_gs = (addr == gaem_pkg::OFS_GS_MASK);
    hit_irq_clear = (addr == gaem_pkg::OFS_IRQ_CLEAR);
    hit_irq_enable = (addr == gaem_pkg::OFS_IRQ_ENABLE);
    wr_state = wr_en && hit_state;
    wr_gs = wr_en && hit_gs;
  end

  // ************************************************************
  // Mask registers
  // ************************************************************
  // Only writable bits move; the rest keep their reset image
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_mask_q <= gaem_pkg::RST_STATE_MASK;
    end else if (wr_state) begin
      state_mask_q <= (state_mask_q & ~gaem_pkg::WMASK_STATE) |
                      (wr_data & gaem_pkg::WMASK_STATE);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      gs_mask_q <= gaem_pkg::RST_GS_MASK;
    end else if (wr_gs) begin
      gs_mask_q <= (gs_mask_q & ~gaem_pkg::WMASK_GS) |
                   (wr_data & gaem_pkg::WMASK_GS);
    end
  end

  // Vendor word follows its source; contents are the vendor's own
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      vendor_latch_q <= gaem_pkg::RST_VENDOR_LATCH;
    end else begin
      vendor_latch_q <= vendor_latch_in;
    end
  end

  // ************************************************************
  // Alarm aggregation
  // ************************************************************
  // Reserved bits 14-8 of the status mask never reach the OR tree
  always_comb begin
    state_hits = state_change_latch & state_mask_q[gaem_pkg::STATE_N-1:0];
    gs_hits = general_status_latch[gaem_pkg::GS_USED_W-1:0] &
              gs_mask_q[gaem_pkg::GS_USED_W-1:0];
    any_source = (|state_hits) || (|gs_hits) || other_enabled_alarm;
    master_en = gs_mask_q[gaem_pkg::GS_MASTER_BIT];
    alarm_d = master_en && any_source;
  end

  // Registered so the pin is glitch free; costs one cycle of latency
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      alarm_q <= 1'b0;
    end else begin
      alarm_q <= alarm_d;
    end
  end

  assign global_alarm_out = alarm_q;

  // ************************************************************
  // Interrupt status, clear and enable
  // ************************************************************
  always_comb begin
    irq_set = '0;
    irq_set[gaem_pkg::IRQ_ALARM_RISE] = alarm_d && !alarm_q;
    irq_set[gaem_pkg::IRQ_ALARM_FALL] = !alarm_d && alarm_q;
    irq_set[gaem_pkg::IRQ_MASK_WRITE] = wr_state || wr_gs;
    irq_clr = (wr_en && hit_irq_clear) ? wr_data[gaem_pkg::IRQ_N-1:0] : 3'h0;
  end

  gaem_sticky #(
    .W(gaem_pkg::IRQ_N)
  ) u_irq_status (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .set_vec(irq_set),
    .clr_vec(irq_clr),
    .flag_q(irq_status_q)
  );

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      irq_enable_q <= gaem_pkg::RST_IRQ_ENABLE;
    end else if (wr_en && hit_irq_enable) begin
      irq_enable_q <= wr_data[gaem_pkg::IRQ_N-1:0];
    end
  end

  assign irq = |(irq_status_q & irq_enable_q);

  // ************************************************************
  // Read path
  // ************************************************************
  // Clear register is write only and reads as zero like a hole
  always_comb begin
    case (addr)
      gaem_pkg::OFS_VENDOR_LATCH: rd_mux = vendor_latch_q;
      gaem_pkg::OFS_STATE_MASK: rd_mux = state_mask_q & gaem_pkg::WMASK_STATE;
      gaem_pkg::OFS_GS_MASK: rd_mux = gs_mask_q;
      gaem_pkg::OFS_IRQ_STATUS: rd_mux = {13'h0, irq_status_q};
      gaem_pkg::OFS_IRQ_ENABLE: rd_mux = {13'h0, irq_enable_q};
      default: rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rd_data_q <= 16'h0000;
    end else begin
      rd_data_q <= rd_en ? rd_mux : 16'h0000;
    end
  end

  assign rd_data = rd_data_q;

  // ************************************************************
  // Assertions
  // ************************************************************
  // Sampled rstn keeps the release edge out; the flops still reset there
  sequence s_state_write;
    rstn && wr_en && (addr == gaem_pkg::OFS_STATE_MASK);
  endsequence

  sequence s_gs_write;
    rstn && wr_en && (addr == gaem_pkg::OFS_GS_MASK);
  endsequence

  sequence s_reset_release;
    !rstn ##1 rstn;
  endsequence

  a_state_mask_reset: assert property (
    @(posedge clk_sys) s_reset_release |-> state_mask_q == 16'h006a
  ) else $error("state mask not 006a after reset");

  a_gs_mask_reset: assert property (
    @(posedge clk_sys) s_reset_release |-> gs_mask_q == 16'ha7f8
  ) else $error("status mask not a7f8 after reset");

  a_state_mask_write: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    s_state_write |=> state_mask_q[8:1] == $past(wr_data[8:1])
  ) else $error("state enable bits did not take write");

  a_init_bit_fixed: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (state_mask_q[0] == 1'b0) && (state_mask_q[15:9] == 7'h00)
  ) else $error("initialize or reserved state bit set");

  a_gs_reserved_hold: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    s_gs_write |=> gs_mask_q[14:8] == 7'h27 && gs_mask_q[7:0] == $past(wr_data[7:0])
  ) else $error("reserved status mask bits moved");

  a_master_blocks: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    !gs_mask_q[15] |=> !global_alarm_out
  ) else $error("alarm high with master enable cleared");

  a_state_source: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (rstn && gs_mask_q[15] && |(state_change_latch & state_mask_q[8:0])) |=> global_alarm_out
  ) else $error("enabled state change did not raise alarm");

  a_gs_source: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (rstn && gs_mask_q[15] && |(general_status_latch[7:0] & gs_mask_q[7:0])) |=>
      global_alarm_out
  ) else $error("enabled status bit did not raise alarm");

  a_gs_reserved_unused: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (general_status_latch[7:0] == 8'h00 && state_change_latch == 9'h000 &&
     !other_enabled_alarm) |=> !global_alarm_out
  ) else $error("alarm from reserved or no source");

  a_alarm_or_tree: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (rstn && gs_mask_q[15] && (other_enabled_alarm ||
      |(state_change_latch & state_mask_q[8:0]) ||
      |(general_status_latch[7:0] & gs_mask_q[7:0]))) |=> global_alarm_out
  ) else $error("alarm low although an enabled source is active");

  a_alarm_quiet: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (rstn && !(gs_mask_q[15] && (other_enabled_alarm ||
      |(state_change_latch & state_mask_q[8:0]) ||
      |(general_status_latch[7:0] & gs_mask_q[7:0])))) |=> !global_alarm_out
  ) else $error("alarm high without an enabled source");

  a_irq_set_wins: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (rstn && irq_set[0] && irq_clr[0]) |=> irq_status_q[0]
  ) else $error("alarm rise event lost on clear");

  a_read_one_cycle: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    !rd_en |=> rd_data == 16'h0000
  ) else $error("read data outside read slot");

endmodule : gaem_top
`default_nettype wire

// ### gaem_pkg.sv
// Constants for the global alarm enable and mask block
package gaem_pkg;

  // ************************************************************
  // Bus geometry
  // ************************************************************
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [15:0] OFS_VENDOR_LATCH = 16'hb027;
  localparam logic [15:0] OFS_STATE_MASK = 16'hb028;
  localparam logic [15:0] OFS_GS_MASK = 16'hb029;
  localparam logic [15:0] OFS_IRQ_STATUS = 16'hb0f0;
  localparam logic [15:0] OFS_IRQ_CLEAR = 16'hb0f1;
  localparam logic [15:0] OFS_IRQ_ENABLE = 16'hb0f2;

  // ************************************************************
  // Reset values and writable bits
  // ************************************************************
  localparam logic [15:0] RST_VENDOR_LATCH = 16'h0000;
  localparam logic [15:0] RST_STATE_MASK = 16'h006a;
  localparam logic [15:0] RST_GS_MASK = 16'ha7f8;
  localparam logic [15:0] WMASK_STATE = 16'h01fe;
  localparam logic [15:0] WMASK_GS = 16'h80ff;
  localparam logic [2:0] RST_IRQ_ENABLE = 3'h0;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int STATE_N = 9;
  localparam int ST_HIPWR_DOWN = 8;
  localparam int ST_TX_TURN_OFF = 7;
  localparam int ST_FAULT = 6;
  localparam int ST_READY = 5;
  localparam int ST_TX_TURN_ON = 4;
  localparam int ST_TX_OFF = 3;
  localparam int ST_HIPWR_UP = 2;
  localparam int ST_LOW_PWR = 1;
  localparam int ST_INIT = 0;
  localparam int GS_MASTER_BIT = 15;
  localparam int GS_USED_W = 8;

  // ************************************************************
  // Interrupt status layout
  // ************************************************************
  localparam int IRQ_N = 3;
  localparam int IRQ_ALARM_RISE = 0;
  localparam int IRQ_ALARM_FALL = 1;
  localparam int IRQ_MASK_WRITE = 2;

endpackage : gaem_pkg

// ### gaem_sticky.sv
// Sticky event bits: set wins over clear
`timescale 1ns/100ps
`default_nettype none
module gaem_sticky #(
  parameter int W = 3
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [W-1:0] set_vec,
  input wire logic [W-1:0] clr_vec,
  output logic [W-1:0] flag_q
);

  logic [W-1:0] flag_d;

  // Simultaneous set and clear keeps the bit, so no event is lost
  always_comb begin
    flag_d = (flag_q & ~clr_vec) | set_vec;
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      flag_q <= '0;
    end else begin
      flag_q <= flag_d;
    end
  end

endmodule : gaem_sticky
`default_nettype wire

// ### gaem_host_mon.sv
// Host side monitor of the global alarm line
`timescale 1ns/100ps
`default_nettype none
module gaem_host_mon (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic global_alarm_out,
  output logic seen_alarm_q
);
  // Host only records that an alarm was seen; it never drives the block
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      seen_alarm_q <= 1'b0;
    end else if (global_alarm_out === 1'b1) begin
      seen_alarm_q <= 1'b1;
    end
  end
endmodule : gaem_host_mon
`default_nettype wire

// ### tb_top.sv
// Register and alarm tests for the global alarm mask block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; \
  $display("BAD %0t value %h expected %h", $time, (a), (b)); end end
module tb_top;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [15:0] wr_data = 16'h0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [15:0] rd_data;
  logic [8:0] st_lat = 9'h000;
  logic [15:0] gs_lat = 16'h0000;
  logic other = 1'b0;
  logic [15:0] vend = 16'h0000;
  logic global_alarm_out;
  logic irq;
  logic seen_alarm_q;
  logic [15:0] v;
  int n_mismatch = 0;
  int comparisons = 0;

  gaem_top i_dut (.clk_sys(clk_sys), .rstn(rstn), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .state_change_latch(st_lat),
    .general_status_latch(gs_lat), .other_enabled_alarm(other), .vendor_latch_in(vend),
    .global_alarm_out(global_alarm_out), .irq(irq));
  gaem_host_mon i_host (.clk_sys(clk_sys), .rstn(rstn), .global_alarm_out(global_alarm_out),
    .seen_alarm_q(seen_alarm_q));

  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  // ************************************************************
  // Bus and stimulus tasks
  // ************************************************************
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask : rd

  // Cause takes one edge to reach the registered alarm
  task automatic drive(input logic [8:0] s, input logic [15:0] g, input logic o);
    @(posedge clk_sys);
    st_lat <= s;
    gs_lat <= g;
    other <= o;
    @(posedge clk_sys);
    #1;
  endtask : drive

  task automatic report_and_stop;
    $display("Mismatches %0d of %0d comparisons", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #200000;
    n_mismatch++;
    report_and_stop();
  end

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(16'hb028, v);
    `CHK(v, 16'h006a)
    rd(16'hb029, v);
    `CHK(v, 16'ha7f8)
    rd(16'hb100, v);
    `CHK(v, 16'h0000)
    wr(16'hb028, 16'hffff);
    rd(16'hb028, v);
    `CHK(v, 16'h01fe)
    wr(16'hb029, 16'h7fff);
    rd(16'hb029, v);
    `CHK(v, 16'h27ff)
    // One enable per state; the initialize enable can never raise the alarm
    for (int i = 0; i < 9; i++) begin
      wr(16'hb028, 16'h0001 << i);
      wr(16'hb029, 16'h8000);
      drive(9'h001 << i, 16'h0000, 1'b0);
      `CHK(global_alarm_out, (i != 0))
      drive(~(9'h001 << i), 16'h0000, 1'b0);
      `CHK(global_alarm_out, 1'b0)
    end
    // Reserved status bits 14-8 stay out of the alarm
    wr(16'hb028, 16'h0000);
    for (int i = 0; i < 15; i++) begin
      wr(16'hb029, 16'h8000 | (16'h0001 << i));
      drive(9'h000, 16'h0001 << i, 1'b0);
      `CHK(global_alarm_out, (i < 8))
      drive(9'h000, ~(16'h0001 << i), 1'b0);
      `CHK(global_alarm_out, 1'b0)
    end
    wr(16'hb029, 16'h0000);
    drive(9'h1ff, 16'h00ff, 1'b1);
    `CHK(global_alarm_out, 1'b0)
    wr(16'hb029, 16'h8000);
    drive(9'h000, 16'h0000, 1'b1);
    `CHK(global_alarm_out, 1'b1)
    // Interrupt on alarm rise: enable, raise, read, clear
    drive(9'h000, 16'h0000, 1'b0);
    wr(16'hb0f1, 16'h0007);
    wr(16'hb0f2, 16'h0001);
    rd(16'hb0f2, v);
    `CHK(v, 16'h0001)
    `CHK(irq, 1'b0)
    drive(9'h000, 16'h0000, 1'b1);
    `CHK(irq, 1'b1)
    rd(16'hb0f0, v);
    `CHK(v[0], 1'b1)
    wr(16'hb0f1, 16'h0001);
    #1;
    `CHK(irq, 1'b0)
    wr(16'hb0f2, 16'h0000);
    drive(9'h000, 16'h0000, 1'b0);
    drive(9'h000, 16'h0000, 1'b1);
    `CHK(irq, 1'b0)
    rd(16'hb0f0, v);
    `CHK(v, 16'h0003)
    drive(9'h000, 16'h0000, 1'b0);
    wr(16'hb0f1, 16'h0007);
    // Rise and clear meet on one edge; the event must survive
    fork
      wr(16'hb0f1, 16'h0001);
      drive(9'h000, 16'h0000, 1'b1);
    join
    rd(16'hb0f0, v);
    `CHK(v, 16'h0001)
    wr(16'hb028, 16'h0000);
    wr(16'hb0f2, 16'h0004);
    #1;
    `CHK(irq, 1'b1)
    rd(16'hb0f1, v);
    `CHK(v, 16'h0000)
    rd(16'hb0f0, v);
    `CHK(v, 16'h0005)
    `CHK(seen_alarm_q, 1'b1)
    @(posedge clk_sys);
    vend <= 16'h5a3c;
    rd(16'hb027, v);
    `CHK(v, 16'h5a3c)
    rd(16'hb027, v);
    `CHK(v, 16'h5a3c)
    // Second reset in mid-run must restore the state mask, status mask and interrupt enable reset images
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(16'hb028, v);
    `CHK(v, 16'h006a)
    rd(16'hb029, v);
    `CHK(v, 16'ha7f8)
    rd(16'hb0f2, v);
    `CHK(v, 16'h0000)
    `CHK(global_alarm_out, 1'b1)
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
